// File: rtl/dtc_pkg.sv
// Constants shared by the dual timer/counter block.
// Assumes a single 20 MHz timer clock and APB register access.
package dtc_pkg;

  // ==========================================================
  // Clocking
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned PER_DIV     = 6;
  localparam logic [2:0]  DIV_LAST    = 3'(PER_DIV - 1);
  localparam int unsigned PIN_N       = 2;

  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_CTRL    = 8'h88;
  localparam logic [7:0]  IDX_MODE    = 8'h89;
  localparam logic [7:0]  IDX_TL0     = 8'h8a;
  localparam logic [7:0]  IDX_TL1     = 8'h8b;
  localparam logic [7:0]  IDX_TH0     = 8'h8c;
  localparam logic [7:0]  IDX_TH1     = 8'h8d;
  localparam logic [7:0]  IDX_IEN     = 8'h8e;
  localparam int unsigned ADDR_W      = 12;
  localparam logic [1:0]  ADDR_LSB    = 2'h0;
  localparam logic [1:0]  ADDR_TOP    = 2'h0;

  // ==========================================================
  // timer_control_status fields
  localparam int unsigned CT_TF1      = 7;
  localparam int unsigned CT_TR1      = 6;
  localparam int unsigned CT_TF0      = 5;
  localparam int unsigned CT_TR0      = 4;
  localparam int unsigned CT_IE1      = 3;
  localparam int unsigned CT_IT1      = 2;
  localparam int unsigned CT_IE0      = 1;
  localparam int unsigned CT_IT0      = 0;

  // timer_mode_select fields
  localparam int unsigned MD_PIN_GATING_ONE    = 7;
  localparam int unsigned MD_SRC1     = 6;
  localparam int unsigned MD_HI1      = 5;
  localparam int unsigned MD_LO1      = 4;
  localparam int unsigned MD_PIN_GATING_ZERO    = 3;
  localparam int unsigned MD_SRC0     = 2;
  localparam int unsigned MD_HI0      = 1;
  localparam int unsigned MD_LO0      = 0;

  // irq_enable_register fields
  localparam int unsigned IEN_GLOBAL  = 7;
  localparam int unsigned IEN_T1      = 3;
  localparam int unsigned IEN_T0      = 1;

  // ==========================================================
  // Operating modes
  localparam logic [1:0]  MODE_13BIT  = 2'h0;
  localparam logic [1:0]  MODE_16BIT  = 2'h1;
  localparam logic [1:0]  MODE_RELOAD = 2'h2;
  localparam logic [1:0]  MODE_SPLIT  = 2'h3;

  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [7:0]  BYTE_ONES   = 8'hff;
  localparam logic [7:0]  BYTE_ONE    = 8'h01;

endpackage

// File: rtl/dtc_pin_if.sv
// Pin samples passed from the pin sampler to the timer core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface dtc_pin_if;
  logic                       tick;
  logic [dtc_pkg::PIN_N-1:0]  gate_lvl;
  logic [dtc_pkg::PIN_N-1:0]  gate_fall;
  logic [dtc_pkg::PIN_N-1:0]  cnt_fall;

  modport sampler (
    input  tick,
    output gate_lvl,
    output gate_fall,
    output cnt_fall
  );
  modport core (
    output tick,
    input  gate_lvl,
    input  gate_fall,
    input  cnt_fall
  );
endinterface

// File: rtl/dtc_pin_sampler.sv
// Synchronises the count and external interrupt pins and samples
// them once per peripheral cycle. Assumes tick is a one-cycle pulse.
`timescale 1ns/1ps
module dtc_pin_sampler (
  input  wire logic                      i_clk,
  input  wire logic                      i_arst_n,
  input  wire logic [dtc_pkg::PIN_N-1:0] i_cnt_pin,
  input  wire logic [dtc_pkg::PIN_N-1:0] i_gate_pin,
  dtc_pin_if.sampler                     pins
);

  // ==========================================================
  // Two-stage synchronisers
  logic [2*dtc_pkg::PIN_N-1:0] meta_q;
  logic [2*dtc_pkg::PIN_N-1:0] sync_q;
  logic [2*dtc_pkg::PIN_N-1:0] smp_q;
  logic [2*dtc_pkg::PIN_N-1:0] fall_q;
  logic [2*dtc_pkg::PIN_N-1:0] fall_d;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {i_gate_pin, i_cnt_pin};
      sync_q <= meta_q;
    end
  end

  // ==========================================================
  // Per-cycle sample: high then low gives one falling event
  assign fall_d = pins.tick ? (smp_q & ~sync_q) : '0;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      smp_q  <= '0;
      fall_q <= '0;
    end else begin
      fall_q <= fall_d;
      if (pins.tick) begin
        smp_q <= sync_q;
      end
    end
  end

  assign pins.cnt_fall  = fall_q[dtc_pkg::PIN_N-1:0];
  assign pins.gate_fall = fall_q[2*dtc_pkg::PIN_N-1:dtc_pkg::PIN_N];
  assign pins.gate_lvl  = smp_q[2*dtc_pkg::PIN_N-1:dtc_pkg::PIN_N];

endmodule

// File: rtl/dtc_timer.sv
// Dual timer/counter with an APB register slave.
// Assumes an interrupt controller that pulses the vector acks and a
// serial port that consumes the baud tick.
//
// Overview of operation
// - Gate clear: low byte advances on selected input only while run set, or for timer 1 while timer 0 is split.
// - Gate and run set: the external interrupt pin decides counting.
// - Gated timer counts while its pin is high and run is set.
// - Rollover from all ones sets the overflow flag, raising a request.
// - Control bits sit at fixed positions of timer_control_status.
// - Two-bit mode field selects 13-bit, 16-bit, reload or split mode.
// - Mode 0: five low bits prescale by 32 into the high byte.
// - Mode 0: upper three low-byte bits are unused and hold.
// - Mode 1: high and low bytes cascade as a 16-bit counter.
// - Mode 2: low byte overflows, reloads from unchanged high byte.
// - Mode 2: a new reload value is used at the next overflow.
// - Timer operation advances once every six clock periods.
// - Timer 0 split: low byte is a normal 8-bit timer/counter.
// - Timer 0 split: high byte times, run by and flagging timer 1.
// - Timer 1 matches timer 0 in modes 0-2; mode 3 holds.
// - Timer 1 overflow is offered to the serial port as baud tick.
// - Vectoring to a timer interrupt clears its overflow flag.
// - Timer interrupt needs its own enable and the global enable.
// - Count pin is sampled per cycle; high then low counts once.
`timescale 1ns/1ps
module dtc_timer (
  input  wire logic                        i_clk,
  input  wire logic                        i_arst_n,
  // APB slave
  input  wire logic                        i_psel,
  input  wire logic                        i_penable,
  input  wire logic                        i_pwrite,
  input  wire logic [dtc_pkg::ADDR_W-1:0]  i_paddr,
  input  wire logic [31:0]                 i_pwdata,
  output logic      [31:0]                 o_prdata,
  output logic                             o_pready,
  output logic                             o_pslverr,
  // Pins
  input  wire logic                        i_count_pin_zero,
  input  wire logic                        i_count_pin_one,
  input  wire logic                        i_ext_irq_pin_zero,
  input  wire logic                        i_ext_irq_pin_one,
  // Interrupt controller
  input  wire logic                        i_vector_ack_timer_zero,
  input  wire logic                        i_vector_ack_timer_one,
  input  wire logic                        i_vector_ack_ext_zero,
  input  wire logic                        i_vector_ack_ext_one,
  output logic                             o_timer_irq_zero,
  output logic                             o_timer_irq_one,
  output logic                             o_ext_irq_zero,
  output logic                             o_ext_irq_one,
  // Serial port
  output logic                             o_baud_tick
);

  // ==========================================================
  // One counting step of a timer: returns {overflow, high, low}
  function automatic logic [16:0] tmr_step(
    input logic [1:0] mode,
    input logic [7:0] hi,
    input logic [7:0] lo,
    input logic       inc
  );
    logic [5:0]  pre;
    logic [8:0]  hi9;
    logic [8:0]  lo9;
    logic [16:0] w17;
    logic [16:0] r;
    pre = {1'h0, lo[4:0]} + 6'h01;
    hi9 = {1'h0, hi} + 9'h001;
    lo9 = {1'h0, lo} + 9'h001;
    w17 = {1'h0, hi, lo} + 17'h00001;
    r   = {1'h0, hi, lo};
    if (inc) begin
      case (mode)
        dtc_pkg::MODE_13BIT: begin
          // Upper three low bits keep their value
          if (pre[5]) begin
            r = {hi9[8], hi9[7:0], lo[7:5], pre[4:0]};
          end else begin
            r = {1'h0, hi, lo[7:5], pre[4:0]};
          end
        end
        dtc_pkg::MODE_16BIT: begin
          r = w17;
        end
        dtc_pkg::MODE_RELOAD: begin
          if (lo9[8]) begin
            r = {1'h1, hi, hi};
          end else begin
            r = {1'h0, hi, lo9[7:0]};
          end
        end
        default: begin
          r = {lo9[8], hi, lo9[7:0]};
        end
      endcase
    end
    return r;
  endfunction

  // ==========================================================
  // Peripheral cycle divider
  logic [2:0] div_q;
  logic       tick;

  assign tick = (div_q == dtc_pkg::DIV_LAST);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_q <= '0;
    end else if (tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  // ==========================================================
  // Pin sampling
  dtc_pin_if pin_bus ();

  assign pin_bus.tick = tick;

  dtc_pin_sampler u_sampler (
    .i_clk      (i_clk),
    .i_arst_n   (i_arst_n),
    .i_cnt_pin  ({i_count_pin_one, i_count_pin_zero}),
    .i_gate_pin ({i_ext_irq_pin_one, i_ext_irq_pin_zero}),
    .pins       (pin_bus.sampler)
  );

  // ==========================================================
  // Registers
  logic [7:0] mode_q;
  logic [7:0] low_count_zero_q;
  logic [7:0] high_count_zero_q;
  logic [7:0] low_count_one_q;
  logic [7:0] high_count_one_q;
  logic [1:0] ovf_q;
  logic [1:0] run_q;
  logic [1:0] edge_q;
  logic [1:0] trig_q;
  logic [2:0] ien_q;
  logic       baud_q;
  logic [31:0] prdata_q;

  // ==========================================================
  // APB decode
  logic [7:0]  idx;
  logic        addr_ok;
  logic        hit_ctrl;
  logic        hit_mode;
  logic        hit_tl0;
  logic        hit_tl1;
  logic        hit_th0;
  logic        hit_th1;
  logic        hit_ien;
  logic        hit_any;
  logic        wr;
  logic        rd_setup;
  logic [7:0]  wdat;
  logic [7:0]  ctrl_rd;
  logic [7:0]  ien_rd;
  logic [7:0]  rd_mux;

  assign idx      = i_paddr[9:2];
  assign addr_ok  = (i_paddr[1:0] == dtc_pkg::ADDR_LSB) &&
                    (i_paddr[11:10] == dtc_pkg::ADDR_TOP);
  assign hit_ctrl = addr_ok && (idx == dtc_pkg::IDX_CTRL);
  assign hit_mode = addr_ok && (idx == dtc_pkg::IDX_MODE);
  assign hit_tl0  = addr_ok && (idx == dtc_pkg::IDX_TL0);
  assign hit_tl1  = addr_ok && (idx == dtc_pkg::IDX_TL1);
  assign hit_th0  = addr_ok && (idx == dtc_pkg::IDX_TH0);
  assign hit_th1  = addr_ok && (idx == dtc_pkg::IDX_TH1);
  assign hit_ien  = addr_ok && (idx == dtc_pkg::IDX_IEN);
  assign hit_any  = hit_ctrl | hit_mode | hit_tl0 | hit_tl1 |
                    hit_th0 | hit_th1 | hit_ien;
  assign wr       = i_psel & i_penable & i_pwrite & hit_any;
  assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
  assign wdat     = i_pwdata[7:0];

  assign ctrl_rd  = {ovf_q[1], run_q[1], ovf_q[0], run_q[0],
                     edge_q[1], trig_q[1], edge_q[0], trig_q[0]};
  assign ien_rd   = {ien_q[2], 3'h0, ien_q[1], 1'h0, ien_q[0], 1'h0};
  assign rd_mux   = hit_ctrl ? ctrl_rd :
                    hit_mode ? mode_q :
                    hit_tl0  ? low_count_zero_q :
                    hit_tl1  ? low_count_one_q :
                    hit_th0  ? high_count_zero_q :
                    hit_th1  ? high_count_one_q :
                    hit_ien  ? ien_rd : dtc_pkg::RST_BYTE;

  // Zero wait states; read data is latched in the setup cycle
  assign o_pready  = 1'h1;
  assign o_pslverr = i_psel & i_penable & ~hit_any;
  assign o_prdata  = prdata_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prdata_q <= '0;
    end else if (rd_setup) begin
      prdata_q <= {24'h000000, rd_mux};
    end
  end

  // ==========================================================
  // Count enables
  logic [1:0]  mode0;
  logic [1:0]  mode1;
  logic        split0;
  logic        run1;
  logic        en0;
  logic        en1;
  logic        inc0;
  logic        inc1;
  logic        inc_hi0;
  logic        ovf_hi0;
  logic [16:0] step0;
  logic [16:0] step1;
  logic [1:0]  ovf_set;

  assign mode0  = {mode_q[dtc_pkg::MD_HI0], mode_q[dtc_pkg::MD_LO0]};
  assign mode1  = {mode_q[dtc_pkg::MD_HI1], mode_q[dtc_pkg::MD_LO1]};
  assign split0 = (mode0 == dtc_pkg::MODE_SPLIT);

  // Gate bit lets the sampled interrupt pin hold the count
  assign en0 = run_q[0] &
               (~mode_q[dtc_pkg::MD_PIN_GATING_ZERO] |
                pin_bus.gate_lvl[0]);
  assign inc0 = en0 & (mode_q[dtc_pkg::MD_SRC0] ?
                       pin_bus.cnt_fall[0] : tick);
  assign step0 = tmr_step(mode0, high_count_zero_q, low_count_zero_q,
                          inc0);

  // High byte of a split timer 0 borrows timer 1 run control
  assign inc_hi0 = split0 & run_q[1] & tick;
  assign ovf_hi0 = inc_hi0 & (high_count_zero_q == dtc_pkg::BYTE_ONES);

  // Timer 1 loses its run bit to a split timer 0 and runs freely
  assign run1 = split0 | run_q[1];
  assign en1  = run1 & (~mode_q[dtc_pkg::MD_PIN_GATING_ONE] |
                        pin_bus.gate_lvl[1]);
  assign inc1 = en1 & (mode1 != dtc_pkg::MODE_SPLIT) &
                (mode_q[dtc_pkg::MD_SRC1] ?
                 pin_bus.cnt_fall[1] : tick);
  assign step1 = tmr_step(mode1, high_count_one_q, low_count_one_q,
                          inc1);

  assign ovf_set[0] = step0[16];
  assign ovf_set[1] = split0 ? ovf_hi0 : step1[16];

  // ==========================================================
  // Count bytes; a bus write wins over the hardware step
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      low_count_zero_q  <= dtc_pkg::RST_BYTE;
      high_count_zero_q <= dtc_pkg::RST_BYTE;
      low_count_one_q   <= dtc_pkg::RST_BYTE;
      high_count_one_q  <= dtc_pkg::RST_BYTE;
    end else begin
      low_count_zero_q <= (wr & hit_tl0) ? wdat : step0[7:0];
      // Split mode: high byte steps on its own tick, not on step0
      if (wr & hit_th0) begin
        high_count_zero_q <= wdat;
      end else if (split0) begin
        if (inc_hi0) begin
          high_count_zero_q <= high_count_zero_q +
                               dtc_pkg::BYTE_ONE;
        end
      end else begin
        high_count_zero_q <= step0[15:8];
      end
      low_count_one_q  <= (wr & hit_tl1) ? wdat : step1[7:0];
      high_count_one_q <= (wr & hit_th1) ? wdat : step1[15:8];
    end
  end

  // ==========================================================
  // Control, flags and mode; hardware set beats any clear
  logic [1:0] ovf_d;
  logic [1:0] edge_d;
  logic [1:0] ovf_wbit;
  logic [1:0] edge_wbit;
  logic [1:0] ovf_ack;
  logic [1:0] edge_ack;
  logic       wr_ctrl;

  assign wr_ctrl   = wr & hit_ctrl;
  assign ovf_wbit  = {wdat[dtc_pkg::CT_TF1], wdat[dtc_pkg::CT_TF0]};
  assign edge_wbit = {wdat[dtc_pkg::CT_IE1], wdat[dtc_pkg::CT_IE0]};
  assign ovf_ack   = {i_vector_ack_timer_one, i_vector_ack_timer_zero};
  assign edge_ack  = {i_vector_ack_ext_one, i_vector_ack_ext_zero};

  assign ovf_d = ovf_set |
                 (wr_ctrl ? ovf_wbit : (ovf_q & ~ovf_ack));

  // Level type follows the pin; edge type latches a falling edge
  assign edge_d = (~trig_q & ~pin_bus.gate_lvl) |
                  (trig_q & (pin_bus.gate_fall |
                   (wr_ctrl ? edge_wbit : (edge_q & ~edge_ack))));

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ovf_q  <= '0;
      run_q  <= '0;
      edge_q <= '0;
      trig_q <= '0;
      mode_q <= dtc_pkg::RST_BYTE;
      ien_q  <= '0;
      baud_q <= 1'h0;
    end else begin
      ovf_q  <= ovf_d;
      edge_q <= edge_d;
      baud_q <= step1[16];
      if (wr_ctrl) begin
        run_q  <= {wdat[dtc_pkg::CT_TR1], wdat[dtc_pkg::CT_TR0]};
        trig_q <= {wdat[dtc_pkg::CT_IT1], wdat[dtc_pkg::CT_IT0]};
      end
      if (wr & hit_mode) begin
        mode_q <= wdat;
      end
      if (wr & hit_ien) begin
        ien_q <= {wdat[dtc_pkg::IEN_GLOBAL], wdat[dtc_pkg::IEN_T1],
                  wdat[dtc_pkg::IEN_T0]};
      end
    end
  end

  // ==========================================================
  // Interrupt requests
  assign o_timer_irq_zero = ovf_q[0] & ien_q[0] & ien_q[2];
  assign o_timer_irq_one  = ovf_q[1] & ien_q[1] & ien_q[2];
  assign o_ext_irq_zero   = edge_q[0];
  assign o_ext_irq_one    = edge_q[1];
  assign o_baud_tick      = baud_q;

endmodule

// File: verif/dtc_timer_checker.sv
// Port-level assertions for the dual timer/counter.
// Assumes one clock domain; bound onto every dtc_timer instance.
`timescale 1ns/1ps
module dtc_timer_checker (
  input wire logic                       i_clk,
  input wire logic                       i_arst_n,
  input wire logic                       i_psel,
  input wire logic                       i_penable,
  input wire logic                       i_pwrite,
  input wire logic [dtc_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0]                o_prdata,
  input wire logic                       o_pready,
  input wire logic                       o_pslverr,
  input wire logic                       i_vector_ack_timer_zero,
  input wire logic                       i_vector_ack_timer_one,
  input wire logic                       o_timer_irq_zero,
  input wire logic                       o_timer_irq_one,
  input wire logic                       o_baud_tick
);
  wire wr_acc = i_psel && i_penable && i_pwrite;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  // ==========================================================
  // Register bus
  a_ready_const: assert property (o_pready)
    else $error("pready low");
  a_err_phase: assert property (o_pslverr |-> i_psel && i_penable)
    else $error("pslverr outside access");
  a_misalign_err: assert property (i_psel && i_penable &&
    i_paddr[1:0] != 2'h0 |-> o_pslverr)
    else $error("misaligned access accepted");
  a_err_rdata_zero: assert property (o_pslverr && !i_pwrite |->
    o_prdata == 32'h0)
    else $error("refused read returned data");
  a_rdata_upper: assert property (o_prdata[31:8] == 24'h0)
    else $error("read data upper bits set");

  // ==========================================================
  // Interrupts and baud tick
  a_ack_clear_irq: assert property (
    i_vector_ack_timer_zero && o_timer_irq_zero |=> !o_timer_irq_zero)
    else $error("ack left timer request up");
  a_irq_fall_cause: assert property ($fell(o_timer_irq_one) |->
    $past(i_vector_ack_timer_one) || $past(wr_acc))
    else $error("timer request dropped without cause");
  a_baud_spaced: assert property (
    o_baud_tick |=> !o_baud_tick [*4])
    else $error("baud ticks too close");

  c_baud: cover property (o_baud_tick);
  c_irq0: cover property ($rose(o_timer_irq_zero));
  c_err: cover property (o_pslverr);
endmodule

bind dtc_timer dtc_timer_checker u_chk (
  .i_clk                   (i_clk),
  .i_arst_n                (i_arst_n),
  .i_psel                  (i_psel),
  .i_penable               (i_penable),
  .i_pwrite                (i_pwrite),
  .i_paddr                 (i_paddr),
  .o_prdata                (o_prdata),
  .o_pready                (o_pready),
  .o_pslverr               (o_pslverr),
  .i_vector_ack_timer_zero (i_vector_ack_timer_zero),
  .i_vector_ack_timer_one  (i_vector_ack_timer_one),
  .o_timer_irq_zero        (o_timer_irq_zero),
  .o_timer_irq_one         (o_timer_irq_one),
  .o_baud_tick             (o_baud_tick)
);

// File: verif/dtc_intc_model.sv
// Interrupt controller and serial port stand-in.
// Assumes level requests; answers with one-cycle vector acks.
`timescale 1ns/1ps
module dtc_intc_model (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_accept,
  input  wire logic [3:0] i_irq,
  input  wire logic       i_baud_tick,
  output logic      [3:0] o_ack,
  output int              o_baud_cnt
);
  // ==========================================================
  // Vectoring: one ack per request, only while accepting
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ack <= 4'h0;
    end else begin
      o_ack <= i_irq & ~o_ack & {4{i_accept}};
    end
  end

  // ==========================================================
  // Baud clock consumer
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_baud_cnt <= 0;
    end else if (i_baud_tick) begin
      o_baud_cnt <= o_baud_cnt + 1;
    end
  end
endmodule

// File: verif/dtc_timer_tb_top.sv
// Self-checking bench for the dual timer/counter.
// Assumes zero-wait APB and a free-running six-clock tick.
`timescale 1ns/1ps
`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("wrong value at %0t: got %h exp %h", $time, (g), (e)); \
  end \
end
module dtc_timer_tb_top;
  localparam logic [11:0] A_CTRL = {2'h0, dtc_pkg::IDX_CTRL, 2'h0};
  localparam logic [11:0] A_MODE = {2'h0, dtc_pkg::IDX_MODE, 2'h0};
  localparam logic [11:0] A_TL0  = {2'h0, dtc_pkg::IDX_TL0, 2'h0};
  localparam logic [11:0] A_TL1  = {2'h0, dtc_pkg::IDX_TL1, 2'h0};
  localparam logic [11:0] A_TH0  = {2'h0, dtc_pkg::IDX_TH0, 2'h0};
  localparam logic [11:0] A_TH1  = {2'h0, dtc_pkg::IDX_TH1, 2'h0};
  localparam logic [11:0] A_IEN  = {2'h0, dtc_pkg::IDX_IEN, 2'h0};
  localparam logic [11:0] REGS [7] = '{A_CTRL, A_MODE, A_TL0, A_TL1,
                                       A_TH0, A_TH1, A_IEN};
  localparam logic [7:0]  IENS [4] = '{8'h00, 8'h02, 8'h80, 8'h82};

  logic        i_clk    = 1'b0;
  logic        i_arst_n = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h0;
  logic [1:0]  cnt_pin  = 2'h3;
  logic [1:0]  ext_pin  = 2'h3;
  logic        accept   = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        baud;
  wire  [3:0]  irq;
  logic [3:0]  ack;
  int          baud_cnt;
  logic [7:0]  rd_d;
  logic        rd_err;
  logic [1:0]  snap;
  int          err_total   = 0;
  int          checks_done = 0;
  int          cyc         = 0;
  int          base;

  dtc_timer u_dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_count_pin_zero(cnt_pin[0]),
    .i_count_pin_one(cnt_pin[1]), .i_ext_irq_pin_zero(ext_pin[0]),
    .i_ext_irq_pin_one(ext_pin[1]), .i_vector_ack_timer_zero(ack[0]),
    .i_vector_ack_timer_one(ack[1]), .i_vector_ack_ext_zero(ack[2]),
    .i_vector_ack_ext_one(ack[3]), .o_timer_irq_zero(irq[0]),
    .o_timer_irq_one(irq[1]), .o_ext_irq_zero(irq[2]),
    .o_ext_irq_one(irq[3]), .o_baud_tick(baud)
  );

  dtc_intc_model u_intc (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_accept(accept),
    .i_irq(irq), .i_baud_tick(baud), .o_ack(ack),
    .o_baud_cnt(baud_cnt)
  );

  always #25 i_clk = ~i_clk;

  // ==========================================================
  // Bus tasks
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk);
    psel   <= 1'b1;
    pwrite <= 1'b1;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge i_clk);
    psel   <= 1'b1;
    pwrite <= 1'b0;
    paddr  <= a;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd_d   = prdata[7:0];
    rd_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    rd(a);
    `CHK(rd_d, e)
  endtask

  // Runs for exactly k ticks between the two control writes
  task automatic win(input logic [7:0] on, input logic [7:0] off,
                     input int k);
    wr(A_CTRL, on);
    repeat (6 * k - 3) @(posedge i_clk);
    #1 snap = irq[1:0];
    wr(A_CTRL, off);
  endtask

  task automatic drop(input int b);
    accept <= 1'b1;
    for (int n = 0; n < 20 && irq[b] === 1'b1; n++) @(posedge i_clk);
    #1 `CHK(irq[b], 1'b0)
    accept <= 1'b0;
  endtask

  task automatic complete_run;
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end

  // ==========================================================
  // Scenarios
  initial begin
    repeat (16) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (10) @(posedge i_clk);
    foreach (REGS[i]) rchk(REGS[i], 8'h00);
    rd(12'h000);
    `CHK(rd_err, 1'b1)
    rd(12'h221);
    `CHK(rd_err, 1'b1)
    wr(A_MODE, 8'h01);
    win(8'h00, 8'h00, 5);
    rchk(A_TL0, 8'h00);
    win(8'h10, 8'h00, 10);
    rchk(A_TL0, 8'h0a);
    wr(A_TL0, 8'hfe);
    wr(A_TH0, 8'h12);
    win(8'h10, 8'h00, 3);
    rchk(A_TL0, 8'h01);
    rchk(A_TH0, 8'h13);
    wr(A_TH0, 8'hff);
    wr(A_TL0, 8'hfe);
    wr(A_IEN, 8'h82);
    win(8'h10, 8'h20, 3);
    `CHK(snap[0], 1'b1)
    rchk(A_TH0, 8'h00);
    rchk(A_CTRL, 8'h20);
    foreach (IENS[i]) begin
      wr(A_IEN, IENS[i]);
      #1 `CHK(irq[0], (IENS[i] == 8'h82))
    end
    drop(0);
    rchk(A_CTRL, 8'h00);
    wr(A_MODE, 8'h00);
    wr(A_TL0, 8'hfe);
    wr(A_TH0, 8'h05);
    win(8'h10, 8'h00, 3);
    rd(A_TL0);
    `CHK(rd_d & 8'h1f, 8'h01)
    `CHK(rd_d & 8'he0, 8'he0)
    rchk(A_TH0, 8'h06);
    wr(A_MODE, 8'h02);
    wr(A_TH0, 8'hfd);
    wr(A_TL0, 8'hfe);
    win(8'h10, 8'h00, 2);
    rchk(A_TL0, 8'hfd);
    rchk(A_TH0, 8'hfd);
    wr(A_TH0, 8'h80);
    win(8'h10, 8'h00, 3);
    rchk(A_TL0, 8'h80);
    wr(A_MODE, 8'h33);
    wr(A_IEN, 8'h88);
    wr(A_TH0, 8'hfe);
    wr(A_TL0, 8'hf0);
    wr(A_TL1, 8'h10);
    win(8'h40, 8'h80, 3);
    `CHK(snap[1], 1'b1)
    rchk(A_TH0, 8'h01);
    rchk(A_TL0, 8'hf0);
    rchk(A_TL1, 8'h10);
    drop(1);
    win(8'h10, 8'h00, 2);
    rchk(A_TL0, 8'hf2);
    rchk(A_TH0, 8'h01);
    wr(A_MODE, 8'h20);
    wr(A_TH1, 8'hfe);
    wr(A_TL1, 8'hfe);
    base = baud_cnt;
    win(8'h40, 8'h00, 6);
    repeat (3) @(posedge i_clk);
    `CHK(baud_cnt - base, 3)
    rchk(A_TL1, 8'hfe);
    wr(A_MODE, 8'h05);
    wr(A_TL0, 8'h00);
    wr(A_CTRL, 8'h10);
    repeat (4) begin
      cnt_pin[0] <= 1'b0;
      repeat (12) @(posedge i_clk);
      cnt_pin[0] <= 1'b1;
      repeat (12) @(posedge i_clk);
    end
    repeat (20) @(posedge i_clk);
    wr(A_CTRL, 8'h00);
    rchk(A_TL0, 8'h04);
    wr(A_MODE, 8'h09);
    wr(A_TL0, 8'h00);
    ext_pin <= 2'h0;
    repeat (20) @(posedge i_clk);
    rchk(A_CTRL, 8'h0a);
    `CHK(irq[3:2], 2'h3)
    win(8'h10, 8'h00, 5);
    rchk(A_TL0, 8'h00);
    ext_pin <= 2'h3;
    repeat (20) @(posedge i_clk);
    win(8'h10, 8'h00, 5);
    rchk(A_TL0, 8'h05);
    `CHK(irq[3:2], 2'h0)
    complete_run();
  end
endmodule
